// >>> rtl/bcd_pkg.sv
`default_nettype none

package bcd_pkg;

    // Bus lines idle high, so the line synchronisers reset to one.
    localparam logic       SYNC_RESET     = 1'b1;
    localparam int         SYNC_STAGES    = 3;
    localparam int         LINE_COUNT     = 2;
    localparam int         LINE_SCL       = 0;
    localparam int         LINE_SDA       = 1;
    localparam logic [1:0] LINE_RESET     = 2'h3;
    localparam logic       FLAG_RESET     = 1'b0;

    typedef enum logic [0:0] {
        BCD_BUS_IDLE   = 1'b0,
        BCD_BUS_ACTIVE = 1'b1
    } bcd_bus_state_t;

    typedef enum logic [1:0] {
        BCD_GEN_IDLE  = 2'b00,
        BCD_GEN_DRIVE = 2'b01,
        BCD_GEN_LOST  = 2'b10
    } bcd_gen_state_t;

endpackage : bcd_pkg

`default_nettype wire

// >>> rtl/bcd_line_sync.sv
`timescale 1ns/100ps
`default_nettype none

module bcd_line_sync (
    input  wire logic                           core_clk,
    input  wire logic                           reset_n,
    input  wire logic                           clk_en,
    input  wire logic [bcd_pkg::LINE_COUNT-1:0] line_in,
    output var  logic [bcd_pkg::LINE_COUNT-1:0] line_filt
);
    import bcd_pkg::*;

    logic [LINE_COUNT-1:0] stage1;
    logic [LINE_COUNT-1:0] stage2;
    logic [LINE_COUNT-1:0] stage3;
    logic [LINE_COUNT-1:0] next_filt;

    // A level only counts once the second and third stages agree, which rejects single-sample glitches.
    always_comb begin
        next_filt = line_filt;
        for (int i = 0; i < LINE_COUNT; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_filt[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1    <= LINE_RESET;
            stage2    <= LINE_RESET;
            stage3    <= LINE_RESET;
            line_filt <= LINE_RESET;
        end else if (clk_en) begin
            stage1    <= line_in;
            stage2    <= stage1;
            stage3    <= stage2;
            line_filt <= next_filt;
        end
    end

endmodule : bcd_line_sync

`default_nettype wire

// >>> rtl/bcd_condition_detect.sv
`timescale 1ns/100ps
`default_nettype none

module bcd_condition_detect (
    input  wire logic core_clk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic scl_out,
    output var  logic scl_oe,
    output var  logic sda_out,
    output var  logic sda_oe,
    input  wire logic start_gen_req,
    input  wire logic ten_bit_mode,
    input  wire logic irq_native_mode,
    input  wire logic start_irq_enable,
    input  wire logic stop_irq_enable,
    input  wire logic hi_byte_strobe,
    input  wire logic hi_byte_match,
    input  wire logic hi_byte_rw,
    input  wire logic full_match_strobe,
    input  wire logic stretch_release,
    input  wire logic start_irq_clear,
    input  wire logic stop_irq_clear,
    input  wire logic collision_clear,
    output var  logic bus_active,
    output var  logic start_det,
    output var  logic stop_det,
    output var  logic restart_det,
    output var  logic slave_reset,
    output var  logic addr_expect,
    output var  logic prior_match,
    output var  logic tx_prepare,
    output var  logic bus_collision,
    output var  logic start_irq_flag,
    output var  logic stop_irq_flag
);
    import bcd_pkg::*;

    logic [LINE_COUNT-1:0] line_filt;
    logic                  scl_f;
    logic                  sda_f;
    logic                  scl_q;
    logic                  sda_q;
    logic                  scl_low_seen;
    bcd_bus_state_t        bus_state;
    bcd_gen_state_t        gen_state;
    logic                  start_cond;
    logic                  stop_cond;
    logic                  restart_cond;
    logic                  start_irq_event;
    logic                  stop_irq_event;

    logic                  next_scl_q;
    logic                  next_sda_q;
    logic                  next_scl_low_seen;
    bcd_bus_state_t        next_bus_state;
    bcd_gen_state_t        next_gen_state;
    logic                  next_scl_oe;
    logic                  next_sda_oe;
    logic                  next_start_det;
    logic                  next_stop_det;
    logic                  next_restart_det;
    logic                  next_slave_reset;
    logic                  next_addr_expect;
    logic                  next_prior_match;
    logic                  next_tx_prepare;
    logic                  next_bus_collision;
    logic                  next_start_irq_flag;
    logic                  next_stop_irq_flag;

    // Edge of SDA with SCL high on both samples; shared by Start and Stop decoding.
    function automatic logic sda_edge_scl_high(input logic prev_sda, input logic cur_sda,
                                               input logic prev_scl, input logic cur_scl,
                                               input logic rising);
        sda_edge_scl_high = prev_scl && cur_scl && (prev_sda != cur_sda) && (cur_sda == rising);
    endfunction : sda_edge_scl_high

    bcd_line_sync u_sync (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .line_in   ({sda_in, scl_in}),
        .line_filt (line_filt)
    );

    assign scl_f = line_filt[LINE_SCL];
    assign sda_f = line_filt[LINE_SDA];

    always_comb begin
        start_cond      = sda_edge_scl_high(sda_q, sda_f, scl_q, scl_f, 1'b0);
        stop_cond       = sda_edge_scl_high(sda_q, sda_f, scl_q, scl_f, 1'b1) && scl_low_seen;
        restart_cond    = start_cond && (bus_state == BCD_BUS_ACTIVE) && scl_low_seen;
        start_irq_event = start_cond && (irq_native_mode || start_irq_enable);
        stop_irq_event  = stop_cond && (irq_native_mode || stop_irq_enable);
    end

    always_comb begin
        next_scl_q          = scl_f;
        next_sda_q          = sda_f;
        next_scl_low_seen   = scl_low_seen;
        next_bus_state      = bus_state;
        next_gen_state      = gen_state;
        next_sda_oe         = sda_oe;
        next_scl_oe         = scl_oe;
        next_start_det      = start_cond && !restart_cond;
        next_stop_det       = stop_cond;
        next_restart_det    = restart_cond;
        next_slave_reset    = start_cond;
        next_addr_expect    = addr_expect;
        next_prior_match    = prior_match;
        next_tx_prepare     = 1'b0;
        next_bus_collision  = bus_collision;
        next_start_irq_flag = start_irq_flag;
        next_stop_irq_flag  = stop_irq_flag;

        // Any SCL low arms Stop and Restart; a new Start or a Stop disarms them again.
        if (!scl_f) begin
            next_scl_low_seen = 1'b1;
        end
        if (start_cond || stop_cond) begin
            next_scl_low_seen = 1'b0;
        end

        if (start_cond) begin
            next_bus_state   = BCD_BUS_ACTIVE;
            next_addr_expect = 1'b1;
            next_scl_oe      = 1'b0;
        end else if (stop_cond) begin
            next_bus_state   = BCD_BUS_IDLE;
            next_addr_expect = 1'b0;
            next_scl_oe      = 1'b0;
        end else if (hi_byte_strobe) begin
            next_addr_expect = 1'b0;
        end

        // Clears come first so that a full match in the same cycle still sets the flag.
        if (stop_cond || (hi_byte_strobe && (!hi_byte_rw || !hi_byte_match))) begin
            next_prior_match = 1'b0;
        end
        if (ten_bit_mode && full_match_strobe && !hi_byte_rw) begin
            next_prior_match = 1'b1;
        end

        // The read only proceeds for a slave that the master fully addressed beforehand.
        if (ten_bit_mode && hi_byte_strobe && hi_byte_match && hi_byte_rw && prior_match) begin
            next_scl_oe     = 1'b1;
            next_tx_prepare = 1'b1;
        end else if (stretch_release) begin
            next_scl_oe = 1'b0;
        end

        case (gen_state)
            BCD_GEN_IDLE: begin
                if (start_gen_req && bus_state == BCD_BUS_IDLE) begin
                    if (!sda_f) begin
                        next_gen_state     = BCD_GEN_LOST;
                        next_bus_collision = 1'b1;
                    end else begin
                        next_gen_state = BCD_GEN_DRIVE;
                        next_sda_oe    = 1'b1;
                    end
                end
            end
            BCD_GEN_DRIVE: begin
                if (!start_gen_req) begin
                    next_gen_state = BCD_GEN_IDLE;
                    next_sda_oe    = 1'b0;
                end
            end
            BCD_GEN_LOST: begin
                if (!start_gen_req) begin
                    next_gen_state = BCD_GEN_IDLE;
                end
            end
            default: begin
                next_gen_state = BCD_GEN_IDLE;
                next_sda_oe    = 1'b0;
            end
        endcase
        if (collision_clear && next_gen_state != BCD_GEN_LOST) begin
            next_bus_collision = 1'b0;
        end

        // A new event in the cycle of a software clear keeps the flag set.
        if (start_irq_clear) begin
            next_start_irq_flag = 1'b0;
        end
        if (start_irq_event) begin
            next_start_irq_flag = 1'b1;
        end
        if (stop_irq_clear) begin
            next_stop_irq_flag = 1'b0;
        end
        if (stop_irq_event) begin
            next_stop_irq_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_q          <= SYNC_RESET;
            sda_q          <= SYNC_RESET;
            scl_low_seen   <= FLAG_RESET;
            bus_state      <= BCD_BUS_IDLE;
            bus_active     <= FLAG_RESET;
            gen_state      <= BCD_GEN_IDLE;
            scl_oe         <= FLAG_RESET;
            sda_oe         <= FLAG_RESET;
            scl_out        <= FLAG_RESET;
            sda_out        <= FLAG_RESET;
            start_det      <= FLAG_RESET;
            stop_det       <= FLAG_RESET;
            restart_det    <= FLAG_RESET;
            slave_reset    <= FLAG_RESET;
            addr_expect    <= FLAG_RESET;
            prior_match    <= FLAG_RESET;
            tx_prepare     <= FLAG_RESET;
            bus_collision  <= FLAG_RESET;
            start_irq_flag <= FLAG_RESET;
            stop_irq_flag  <= FLAG_RESET;
        end else if (clk_en) begin
            scl_q          <= next_scl_q;
            sda_q          <= next_sda_q;
            scl_low_seen   <= next_scl_low_seen;
            bus_state      <= next_bus_state;
            bus_active     <= (next_bus_state == BCD_BUS_ACTIVE);
            gen_state      <= next_gen_state;
            scl_oe         <= next_scl_oe;
            sda_oe         <= next_sda_oe;
            scl_out        <= FLAG_RESET;
            sda_out        <= FLAG_RESET;
            start_det      <= next_start_det;
            stop_det       <= next_stop_det;
            restart_det    <= next_restart_det;
            slave_reset    <= next_slave_reset;
            addr_expect    <= next_addr_expect;
            prior_match    <= next_prior_match;
            tx_prepare     <= next_tx_prepare;
            bus_collision  <= next_bus_collision;
            start_irq_flag <= next_start_irq_flag;
            stop_irq_flag  <= next_stop_irq_flag;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    chk_start_seen: assert property (
        (clk_en && sda_q && !sda_f && scl_q && scl_f) |=> (start_det || restart_det) && slave_reset)
        else $error("Start edge not reported.");

    chk_stop_armed: assert property ($rose(stop_det) |-> $past(scl_low_seen) && !bus_active)
        else $error("Stop reported without a prior SCL low period.");

    chk_stop_edge: assert property (
        (clk_en && !sda_q && sda_f && scl_q && scl_f && scl_low_seen) |=> stop_det)
        else $error("Stop edge not reported.");

    chk_restart_valid: assert property (
        $rose(restart_det) |-> $past(scl_low_seen) && $past(bus_state == BCD_BUS_ACTIVE))
        else $error("Restart reported where a Stop would not be valid.");

    chk_restart_reset: assert property ($rose(restart_det) |-> slave_reset && addr_expect && !start_det)
        else $error("Restart did not reset the slave logic.");

    chk_start_collide: assert property (
        (clk_en && gen_state == BCD_GEN_IDLE && start_gen_req && bus_state == BCD_BUS_IDLE && !sda_f)
        |=> bus_collision && !sda_oe)
        else $error("Collision on Start not flagged.");

    chk_prior_stop: assert property (
        (clk_en && stop_cond && !full_match_strobe) |=> !prior_match)
        else $error("Prior match survived a Stop.");

    chk_read_stretch: assert property (
        (clk_en && ten_bit_mode && hi_byte_strobe && hi_byte_match && hi_byte_rw && prior_match)
        |=> scl_oe && tx_prepare ##1 (scl_oe || $past(stretch_release || start_cond || stop_cond)))
        else $error("Clock not held after 10-bit read request.");

    chk_irq_enabled: assert property (
        (clk_en && start_cond && start_irq_enable) |=> start_irq_flag)
        else $error("Enabled Start did not set its flag.");

    chk_irq_native: assert property (
        (clk_en && stop_cond && irq_native_mode && !stop_irq_enable) |=> stop_irq_flag)
        else $error("Native mode Stop interrupt suppressed.");

    chk_irq_masked: assert property (
        (clk_en && !irq_native_mode && !start_irq_enable && !start_irq_flag) |=> !start_irq_flag)
        else $error("Masked Start set its flag.");

    cov_start: cover property ($rose(start_det));
    cov_restart: cover property ($rose(restart_det));
    cov_stop: cover property ($rose(stop_det));
    cov_collision: cover property ($rose(bus_collision));
    cov_stretch: cover property ($rose(tx_prepare));

endmodule : bcd_condition_detect

`default_nettype wire

// >>> bench/bcd_master_model.sv
`timescale 1ns/100ps
`default_nettype none

module bcd_master_model (
    input  wire logic core_clk,
    input  wire logic scl_w,
    output var  logic scl_low,
    output var  logic sda_low
);
    // Steps sit 13 ns past a core edge so no line change lands on a sampling edge.
    // SCL stands still high between frames; the lines are released to the pull-ups.
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic sync_step();
        @(posedge core_clk);
        #13;
    endtask : sync_step

    task automatic frame_start();
        sync_step();
        sda_low = 1'b1;
        #160;
        scl_low = 1'b1;
        #160;
    endtask : frame_start

    task automatic send_bit(input logic b);
        sync_step();
        sda_low = !b;
        #160;
        scl_low = 1'b0;
        #160;
        scl_low = 1'b1;
        #160;
    endtask : send_bit

    task automatic restart();
        sync_step();
        sda_low = 1'b0;
        #160;
        scl_low = 1'b0;
        #160;
        sda_low = 1'b1;
        #160;
        scl_low = 1'b1;
        #160;
    endtask : restart

    task automatic glitch();
        sync_step();
        sda_low = 1'b1;
        #160;
        sda_low = 1'b0;
        #160;
    endtask : glitch

    task automatic frame_stop();
        sync_step();
        scl_low = 1'b1;
        #160;
        sda_low = 1'b1;
        #160;
        scl_low = 1'b0;
        #160;
        sda_low = 1'b0;
        #160;
    endtask : frame_stop

    task automatic park_low(input logic on);
        sync_step();
        if (on) begin
            scl_low = 1'b1;
            #160;
            sda_low = 1'b1;
        end else begin
            sda_low = 1'b0;
            #160;
            scl_low = 1'b0;
        end
        #160;
    endtask : park_low

    // A held clock is waited out, but only for a bounded time.
    task automatic release_scl();
        int n;
        sync_step();
        scl_low = 1'b0;
        n = 0;
        while (scl_w !== 1'b1 && n < 100) begin
            #40;
            n++;
        end
    endtask : release_scl

endmodule : bcd_master_model

`default_nettype wire

// >>> bench/tb_i2c_bus_condition_detect.sv
`timescale 1ns/100ps
`default_nettype none

module tb_i2c_bus_condition_detect;
    logic core_clk, reset_n, clk_en, scl_w, sda_w, m_scl_low, m_sda_low;
    logic scl_out, scl_oe, sda_out, sda_oe, start_gen_req, ten_bit_mode, irq_native_mode;
    logic start_irq_enable, stop_irq_enable, hi_byte_strobe, hi_byte_match, hi_byte_rw;
    logic full_match_strobe, stretch_release, start_irq_clear, stop_irq_clear, collision_clear;
    logic bus_active, start_det, stop_det, restart_det, slave_reset, addr_expect;
    logic prior_match, tx_prepare, bus_collision, start_irq_flag, stop_irq_flag;
    int   n_errors, checks, n_start, n_stop, n_restart, n_reset, n_tx;

    // Open-drain wires: any party pulling low wins, otherwise the pull-up holds them high.
    assign scl_w = (m_scl_low || (scl_oe && !scl_out)) ? 1'b0 : 1'b1;
    assign sda_w = (m_sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    bcd_master_model u_master (.core_clk(core_clk), .scl_w(scl_w), .scl_low(m_scl_low), .sda_low(m_sda_low));

    bcd_condition_detect u_dut (
        .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl_w), .sda_in(sda_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .start_gen_req(start_gen_req), .ten_bit_mode(ten_bit_mode), .irq_native_mode(irq_native_mode),
        .start_irq_enable(start_irq_enable), .stop_irq_enable(stop_irq_enable),
        .hi_byte_strobe(hi_byte_strobe), .hi_byte_match(hi_byte_match), .hi_byte_rw(hi_byte_rw),
        .full_match_strobe(full_match_strobe), .stretch_release(stretch_release),
        .start_irq_clear(start_irq_clear), .stop_irq_clear(stop_irq_clear), .collision_clear(collision_clear),
        .bus_active(bus_active), .start_det(start_det), .stop_det(stop_det), .restart_det(restart_det),
        .slave_reset(slave_reset), .addr_expect(addr_expect), .prior_match(prior_match),
        .tx_prepare(tx_prepare), .bus_collision(bus_collision),
        .start_irq_flag(start_irq_flag), .stop_irq_flag(stop_irq_flag)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // Pulses are counted per edge, so a pulse held two cycles shows up as a wrong count.
    always @(posedge core_clk) begin
        if (start_det === 1'b1) n_start++;
        if (stop_det === 1'b1) n_stop++;
        if (restart_det === 1'b1) n_restart++;
        if (slave_reset === 1'b1) n_reset++;
        if (tx_prepare === 1'b1) n_tx++;
    end

    // Wide enough that a counter packed beside status bits is never cut off.
    task automatic check(input logic [127:0] got, input logic [127:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic clear_counts();
        @(negedge core_clk);
        {n_start, n_stop, n_restart, n_reset, n_tx} = '0;
    endtask : clear_counts

    task automatic settle();
        repeat (8) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic pulse(input int k, input logic m, input logic rw);
        @(posedge core_clk);
        hi_byte_match <= m;
        hi_byte_rw    <= rw;
        case (k)
            0: full_match_strobe <= 1'b1;
            1: hi_byte_strobe <= 1'b1;
            2: stretch_release <= 1'b1;
            3: start_irq_clear <= 1'b1;
            4: stop_irq_clear <= 1'b1;
            default: collision_clear <= 1'b1;
        endcase
        @(posedge core_clk);
        {full_match_strobe, hi_byte_strobe, stretch_release} <= 3'h0;
        {start_irq_clear, stop_irq_clear, collision_clear}   <= 3'h0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : pulse

    task automatic t_reset();
        clear_counts();
        settle();
        check({bus_active, addr_expect, prior_match, bus_collision, scl_oe, sda_oe, scl_out, sda_out}, 32'h0);
        check(n_start + n_stop + n_reset, 32'h0);
        // With the enable low the synchronisers must not even see the line change.
        @(posedge core_clk);
        clk_en <= 1'b0;
        u_master.glitch();
        settle();
        @(posedge core_clk);
        clk_en <= 1'b1;
        settle();
        check({n_start, bus_active, start_det}, 32'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_glitch_stop();
        @(posedge core_clk);
        {start_irq_enable, stop_irq_enable, irq_native_mode} <= 3'h6;
        clear_counts();
        u_master.glitch();
        settle();
        check({n_start, n_stop}, {32'h1, 32'h0});
        check({bus_active, addr_expect, start_irq_flag}, 32'h7);
        u_master.frame_stop();
        settle();
        check({n_stop, bus_active, stop_irq_flag, start_irq_flag}, {32'h1, 3'h3});
        check(stop_irq_flag, 1'b1);
        pulse(3, 1'b0, 1'b0);
        check({start_irq_flag, stop_irq_flag}, 32'h1);
        pulse(4, 1'b0, 1'b0);
        check(stop_irq_flag, 1'b0);
        @(posedge core_clk);
        {start_irq_enable, stop_irq_enable, irq_native_mode} <= 3'h1;
        u_master.glitch();
        u_master.frame_stop();
        settle();
        check({start_irq_flag, stop_irq_flag}, 32'h3);
        pulse(3, 1'b0, 1'b0);
        pulse(4, 1'b0, 1'b0);
        check({start_irq_flag, stop_irq_flag}, 32'h0);
        @(posedge core_clk);
        irq_native_mode <= 1'b0;
        $display("test glitch and stop done");
    endtask : t_glitch_stop

    task automatic t_restart();
        clear_counts();
        u_master.frame_start();
        u_master.send_bit(1'b1);
        pulse(1, 1'b1, 1'b0);
        check(addr_expect, 1'b0);
        u_master.restart();
        settle();
        check({n_start, n_restart, n_reset}, {32'h1, 32'h1, 32'h2});
        check({addr_expect, bus_active, start_irq_flag}, 32'h6);
        u_master.frame_stop();
        $display("test restart done");
    endtask : t_restart

    task automatic t_ten_bit();
        pulse(0, 1'b0, 1'b0);
        check(prior_match, 1'b0);
        @(posedge core_clk);
        ten_bit_mode <= 1'b1;
        clear_counts();
        u_master.frame_start();
        pulse(0, 1'b0, 1'b0);
        check(prior_match, 1'b1);
        u_master.send_bit(1'b0);
        u_master.restart();
        pulse(1, 1'b1, 1'b1);
        check({n_tx, scl_oe, addr_expect, prior_match}, {32'h1, 3'h5});
        fork
            u_master.release_scl();
            begin
                repeat (10) @(posedge core_clk);
                check(scl_w, 1'b0);
                pulse(2, 1'b0, 1'b0);
            end
        join
        settle();
        check({scl_oe, scl_w}, 32'h1);
        pulse(1, 1'b1, 1'b0);
        check(prior_match, 1'b0);
        pulse(0, 1'b0, 1'b0);
        pulse(1, 1'b0, 1'b1);
        check(prior_match, 1'b0);
        pulse(0, 1'b0, 1'b0);
        check(prior_match, 1'b1);
        u_master.frame_stop();
        settle();
        check(prior_match, 1'b0);
        @(posedge core_clk);
        ten_bit_mode <= 1'b0;
        $display("test ten bit done");
    endtask : t_ten_bit

    task automatic t_collision();
        u_master.park_low(1'b1);
        @(posedge core_clk);
        start_gen_req <= 1'b1;
        pulse(5, 1'b0, 1'b0);
        check({bus_collision, sda_oe, bus_active}, 32'h4);
        @(posedge core_clk);
        start_gen_req <= 1'b0;
        pulse(5, 1'b0, 1'b0);
        check(bus_collision, 1'b0);
        u_master.park_low(1'b0);
        clear_counts();
        @(posedge core_clk);
        start_gen_req <= 1'b1;
        settle();
        check({sda_oe, bus_collision, bus_active, n_start}, {3'h5, 32'h1});
        @(posedge core_clk);
        start_gen_req <= 1'b0;
        settle();
        check({sda_oe, bus_active, n_stop}, {2'h1, 32'h0});
        u_master.frame_stop();
        $display("test collision done");
    endtask : t_collision

    task automatic print_verdict();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        {n_errors, checks, n_start, n_stop, n_restart, n_reset, n_tx} = '0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        {start_gen_req, ten_bit_mode, irq_native_mode, start_irq_enable, stop_irq_enable} = 5'h0;
        {hi_byte_strobe, hi_byte_match, hi_byte_rw, full_match_strobe, stretch_release} = 5'h0;
        {start_irq_clear, stop_irq_clear, collision_clear} = 3'h0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        t_reset();
        t_glitch_stop();
        t_restart();
        t_ten_bit();
        t_collision();
        print_verdict();
    end

    // The whole sequence needs well under 40 us; this limit only trips on a hang.
    initial begin
        #400000;
        n_errors++;
        print_verdict();
    end
endmodule : tb_i2c_bus_condition_detect

`default_nettype wire
